//--- rtl/cmac_core.sv
// CPU operating-mode selection, address generation and execution timing.
// Assumes mode pins are static around reset and the decoder issues one op
// at a time while o_ready is high; memory sits on the internal bus.
`timescale 1ns/100ps

// Overview of operation
// - Advanced mode gives linear 16-Mbyte addressing
// - Normal mode limits addressing to 64 kbytes
// - Mode pins choose normal or advanced mode
// - Normal mode unsupported here; flagged invalid
// - Normal mode keeps low 16 address bits
// - Increment carry propagates into upper half
// - Normal vectors are 16-bit entries from zero
// - Normal indirect target is word below 0xff
// - Advanced vectors 32-bit, low 24 bits used
// - Advanced indirect longword, top byte zero
// - Upper halves usable standalone or combined
// - Extended control reg skipped in mode 0
// - Add one state; divides 12 and 20
// - Multiplies take two and three states
// - Extending multiplies take two and three states, +1 after MAC
// - Accumulator ops one state, +1 after MAC
// - Sleep instruction enters power-down state
// - Fetch address forces bit zero low
module cmac_core (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  input  wire logic [1:0]                i_mode_pin,
  input  wire logic                      i_wake,
  input  wire cmac_pkg::cmac_issue_type  i_issue,
  input  wire cmac_pkg::cmac_ea_req_type i_ea_req,
  input  wire logic [7:0]                i_vec_num,
  input  wire logic [7:0]                i_ind_addr,
  input  wire logic [31:0]               i_ind_data,
  input  wire logic [23:0]               i_pc,
  input  wire logic                      i_int_mode0,
  output logic                           o_mode_adv,
  output logic                           o_mode_invalid,
  output cmac_pkg::cmac_ea_rsp_type      o_ea_rsp,
  output logic [23:0]                    o_fetch_addr,
  output logic [23:0]                    o_vec_addr,
  output logic [23:0]                    o_ind_ptr,
  output logic [23:0]                    o_ind_target,
  output logic                           o_push_ext,
  output logic                           o_ready,
  output logic                           o_done,
  output logic                           o_sleep
);
  import cmac_pkg::*;

  // ==========================================================================
  // Mode pin synchroniser and mode latch
  logic [1:0]     pin_s1;
  logic [1:0]     pin_s2;
  logic           in_reset;
  cmac_mode_type  mode;
  cmac_mode_type  next_mode;
  logic           next_in_reset;

  always_comb begin
    next_mode     = mode;
    next_in_reset = 1'b0;
    if (in_reset) begin
      if (pin_s2 == MODE_PIN_NORM) begin
        next_mode = CMAC_MODE_INVALID;
      end else begin
        next_mode = CMAC_MODE_ADVANCED;
      end
    end
  end

  // Synchroniser runs through reset so the pins are settled at release
  always_ff @(posedge i_clk_sys) begin
    pin_s1 <= i_mode_pin;
    pin_s2 <= pin_s1;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      in_reset <= 1'b1;
      mode     <= CMAC_MODE_ADVANCED;
    end else begin
      in_reset <= next_in_reset;
      mode     <= next_mode;
    end
  end

  logic adv;
  assign adv            = (mode == CMAC_MODE_ADVANCED);
  assign o_mode_adv     = adv;
  assign o_mode_invalid = (mode == CMAC_MODE_INVALID);

  // ==========================================================================
  // Address generation
  cmac_ea_rsp_type next_ea_rsp;
  logic [23:0]     next_fetch;
  logic [23:0]     next_vec;
  logic [23:0]     next_ptr;
  logic [23:0]     next_target;
  logic            next_push_ext;
  logic [23:0]     addr_mask;
  logic [31:0]     ea_full;
  logic [31:0]     upd;
  logic [23:0]     vec_step;

  always_comb begin
    addr_mask = adv ? ADV_MASK : NORM_MASK;
    vec_step  = adv ? VEC_STEP_ADV : VEC_STEP_NORM;
    // Full 32-bit arithmetic so carries reach the upper half
    upd = i_ea_req.base;
    if (i_ea_req.pre_dec) begin
      upd = i_ea_req.base - i_ea_req.step;
    end else if (i_ea_req.post_inc) begin
      upd = i_ea_req.base + i_ea_req.step;
    end
    ea_full = i_ea_req.pre_dec ? upd : i_ea_req.base;
    next_ea_rsp.addr    = ea_full[23:0] & addr_mask;
    next_ea_rsp.reg_upd = upd;
    next_fetch  = i_pc & addr_mask & FETCH_ALIGN;
    next_vec    = (VEC_BASE + (24'(i_vec_num) * vec_step)) & addr_mask;
    next_ptr    = 24'(i_ind_addr) & MEMIND_MASK;
    if (adv) begin
      next_target = 24'(i_ind_data & TOP8_CLEAR);
    end else begin
      next_target = 24'(i_ind_data[NORM_W-1:0]);
    end
    next_push_ext = ~i_int_mode0;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ea_rsp     <= '0;
      o_fetch_addr <= 24'h000000;
      o_vec_addr   <= 24'h000000;
      o_ind_ptr    <= 24'h000000;
      o_ind_target <= 24'h000000;
      o_push_ext   <= 1'b0;
    end else begin
      o_ea_rsp     <= next_ea_rsp;
      o_fetch_addr <= next_fetch;
      o_vec_addr   <= next_vec;
      o_ind_ptr    <= next_ptr;
      o_ind_target <= next_target;
      o_push_ext   <= next_push_ext;
    end
  end

  // ==========================================================================
  // Execution timing
  cmac_state_type state;
  cmac_state_type next_state;
  logic [4:0]     count;
  logic [4:0]     next_count;
  logic           after_mac;
  logic           next_after_mac;
  logic           next_done;
  logic [4:0]     states;
  logic           mac_sens;

  always_comb begin
    states   = ST_ONE;
    mac_sens = 1'b0;
    unique case (i_issue.op)
      OP_ADD:   states = ST_ADD;
      OP_DIV16: states = ST_DIV16;
      OP_DIV32: states = ST_DIV32;
      OP_MUL8:  states = ST_MUL8;
      OP_MUL16: states = ST_MUL16;
      OP_UNSIGNED_EXTEND_MULTIPLY: begin
        states   = ST_UNSIGNED_EXTEND_MULTIPLY;
        mac_sens = 1'b1;
      end
      OP_SIGNED_EXTEND_MULTIPLY: begin
        states   = ST_SIGNED_EXTEND_MULTIPLY;
        mac_sens = 1'b1;
      end
      OP_ACLR, OP_ALD, OP_AST: begin
        states   = ST_ACC;
        mac_sens = 1'b1;
      end
      default:  states = ST_ONE;
    endcase
    if (mac_sens && after_mac) begin
      states = states + ST_MAC_PENALTY;
    end
  end

  always_comb begin
    next_state     = state;
    next_count     = count;
    next_after_mac = after_mac;
    next_done      = 1'b0;
    unique case (state)
      CMAC_RUN: begin
        if (i_issue.valid && i_issue.op != OP_NONE) begin
          next_after_mac = (i_issue.op == OP_MAC);
          if (i_issue.op == OP_SLEEP) begin
            next_state = CMAC_SLEEP;
            next_done  = 1'b1;
          end else if (states == ST_ONE) begin
            next_done = 1'b1;
          end else begin
            next_count = states - ST_ONE;
            next_state = CMAC_BUSY;
          end
        end
      end
      CMAC_BUSY: begin
        next_count = count - ST_ONE;
        if (count == ST_ONE) begin
          next_done  = 1'b1;
          next_state = CMAC_RUN;
        end
      end
      CMAC_SLEEP: begin
        if (i_wake) begin
          next_state = CMAC_RUN;
        end
      end
      default: next_state = CMAC_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state     <= CMAC_RUN;
      count     <= ST_ZERO;
      after_mac <= 1'b0;
      o_done    <= 1'b0;
    end else begin
      state     <= next_state;
      count     <= next_count;
      after_mac <= next_after_mac;
      o_done    <= next_done;
    end
  end

  assign o_ready = (state == CMAC_RUN);
  assign o_sleep = (state == CMAC_SLEEP);

endmodule

//--- rtl/cmac_pkg.sv
// Constants and carrier types for the CPU mode and address generation core.
// Assumes a single 10 MHz system clock; no software-visible registers.
package cmac_pkg;

  // ==========================================================================
  // Widths and address limits
  localparam int          ADDR_W         = 24;
  localparam int          NORM_W         = 16;
  localparam int          REG_W          = 32;
  localparam int          HALF_W         = 16;
  localparam logic [23:0] NORM_MASK      = 24'h00ffff;
  localparam logic [23:0] ADV_MASK       = 24'hffffff;
  localparam logic [23:0] MEMIND_MASK    = 24'h0000ff;
  localparam logic [23:0] VEC_BASE       = 24'h000000;
  localparam logic [23:0] VEC_STEP_NORM  = 24'h000002;
  localparam logic [23:0] VEC_STEP_ADV   = 24'h000004;
  localparam logic [23:0] FETCH_ALIGN    = 24'hfffffe;
  localparam logic [31:0] TOP8_CLEAR     = 32'h00ffffff;
  localparam logic [31:0] STEP_NONE      = 32'h00000000;

  // ==========================================================================
  // Mode pin encodings
  localparam logic [1:0]  MODE_PIN_NORM  = 2'h0;

  // ==========================================================================
  // Execution state counts
  localparam logic [4:0]  ST_ADD         = 5'h01;
  localparam logic [4:0]  ST_MUL8        = 5'h02;
  localparam logic [4:0]  ST_MUL16       = 5'h03;
  localparam logic [4:0]  ST_DIV16       = 5'h0c;
  localparam logic [4:0]  ST_DIV32       = 5'h14;
  localparam logic [4:0]  ST_UNSIGNED_EXTEND_MULTIPLY       = 5'h02;
  localparam logic [4:0]  ST_SIGNED_EXTEND_MULTIPLY       = 5'h03;
  localparam logic [4:0]  ST_ACC         = 5'h01;
  localparam logic [4:0]  ST_MAC_PENALTY = 5'h01;
  localparam logic [4:0]  ST_ONE         = 5'h01;
  localparam logic [4:0]  ST_ZERO        = 5'h00;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CMAC_MODE_ADVANCED = 2'h0,
    CMAC_MODE_NORMAL   = 2'h1,
    CMAC_MODE_INVALID  = 2'h3
  } cmac_mode_type;

  typedef enum logic [3:0] {
    OP_NONE  = 4'h0, OP_ADD   = 4'h1, OP_MUL8  = 4'h2, OP_MUL16 = 4'h3,
    OP_DIV16 = 4'h4, OP_DIV32 = 4'h5, OP_UNSIGNED_EXTEND_MULTIPLY = 4'h6, OP_SIGNED_EXTEND_MULTIPLY = 4'h7,
    OP_MAC   = 4'h8, OP_ACLR  = 4'h9, OP_ALD   = 4'ha, OP_AST   = 4'hb,
    OP_SLEEP = 4'hc
  } cmac_op_type;

  typedef enum logic [1:0] {
    CMAC_RUN   = 2'h0,
    CMAC_BUSY  = 2'h1,
    CMAC_SLEEP = 2'h3
  } cmac_state_type;

  typedef struct packed {
    logic        valid;
    cmac_op_type op;
  } cmac_issue_type;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] step;
    logic        pre_dec;
    logic        post_inc;
  } cmac_ea_req_type;

  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] reg_upd;
  } cmac_ea_rsp_type;

endpackage

//--- testbench/cmac_mem_model.sv
// Behavioural memory answering indirect branch pointer reads.
// Assumes the pointer comes straight from the core's o_ind_ptr.
`timescale 1ns/100ps
module cmac_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic [23:0] i_ptr,
  output logic      [31:0] o_data
);
  logic tog = 1'b0;
  always @(posedge i_clk_sys) tog <= ~tog;
  // ==========================================
  // Longword table, top byte filled with junk
  always_comb begin
    if (i_ptr[23:8] == 16'h0000) begin
      o_data = {8'ha5, ~i_ptr[7:0], 8'h3c, i_ptr[7:0]};
    end else begin
      o_data = {32{tog}};
    end
  end
endmodule

//--- testbench/cmac_core_chk.sv
// Assertion checker for the mode and address core.
// Bound to the core's ports from the testbench top file.
`timescale 1ns/100ps
module cmac_core_chk (
  input wire logic                     i_clk_sys,
  input wire logic                     i_rst,
  input wire logic                     i_wake,
  input wire cmac_pkg::cmac_issue_type i_issue,
  input wire logic [23:0]              i_pc,
  input wire logic                     i_int_mode0,
  input wire logic                     o_mode_adv,
  input wire logic [23:0]              o_fetch_addr,
  input wire logic                     o_push_ext,
  input wire logic                     o_ready,
  input wire logic                     o_done,
  input wire logic                     o_sleep
);
  import cmac_pkg::*;
  wire logic tk = o_ready && i_issue.valid;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ==========================================
  // Assertions
  AST_FETCH: assert property (o_mode_adv && !$past(i_rst) |->
    o_fetch_addr == ($past(i_pc) & 24'hfffffe)) else $error("fetch address wrong");
  AST_PUSH: assert property (!$past(i_rst) |->
    o_push_ext == !$past(i_int_mode0)) else $error("push flag wrong");
  AST_ADD: assert property (tk && i_issue.op == OP_ADD |-> ##1 o_done)
    else $error("add count wrong");
  AST_MUL8: assert property (tk && i_issue.op == OP_MUL8 |=> !o_done ##1 o_done)
    else $error("mul8 count wrong");
  AST_MUL16: assert property (tk && i_issue.op == OP_MUL16 |=> !o_done[*2] ##1 o_done)
    else $error("mul16 count wrong");
  AST_DIV16: assert property (tk && i_issue.op == OP_DIV16 |=> !o_ready[*8] ##4 o_done)
    else $error("div16 count wrong");
  AST_DIV32: assert property (tk && i_issue.op == OP_DIV32 |-> ##20 o_done)
    else $error("div32 count wrong");
  AST_SLEEP: assert property (tk && i_issue.op == OP_SLEEP |-> ##1 o_sleep)
    else $error("sleep not entered");
  AST_SLEEP_HOLD: assert property (o_sleep && !i_wake |=> o_sleep)
    else $error("sleep left early");
  AST_MODE: assert property (!$past(i_rst) && !$past(i_rst, 2) |-> $stable(o_mode_adv))
    else $error("mode changed");
  cover property (tk && i_issue.op == OP_MAC);
  cover property (tk && i_issue.op == OP_DIV32);
  cover property (o_sleep && i_wake);
endmodule

//--- testbench/test_cmac_core.sv
// Self-checking bench for the mode and address core.
// Drives inputs on the falling edge; memory model feeds indirect data.
`timescale 1ns/100ps
module test_cmac_core;
  import cmac_pkg::*;
  logic i_clk_sys, i_rst, i_wake, i_int_mode0, o_mode_adv, o_mode_invalid;
  logic o_push_ext, o_ready, o_done, o_sleep;
  logic [1:0] i_mode_pin;
  logic [7:0] i_vec_num, i_ind_addr;
  logic [23:0] i_pc, o_fetch_addr, o_vec_addr, o_ind_ptr, o_ind_target;
  logic [31:0] i_ind_data;
  cmac_issue_type i_issue;
  cmac_ea_req_type i_ea_req;
  cmac_ea_rsp_type o_ea_rsp;
  int num_errors = 0, check_count = 0, cycles = 0;
  cmac_core u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mode_pin(i_mode_pin),
    .i_wake(i_wake), .i_issue(i_issue), .i_ea_req(i_ea_req), .i_vec_num(i_vec_num),
    .i_ind_addr(i_ind_addr), .i_ind_data(i_ind_data), .i_pc(i_pc),
    .i_int_mode0(i_int_mode0), .o_mode_adv(o_mode_adv), .o_mode_invalid(o_mode_invalid),
    .o_ea_rsp(o_ea_rsp), .o_fetch_addr(o_fetch_addr), .o_vec_addr(o_vec_addr),
    .o_ind_ptr(o_ind_ptr), .o_ind_target(o_ind_target), .o_push_ext(o_push_ext),
    .o_ready(o_ready), .o_done(o_done), .o_sleep(o_sleep));
  cmac_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_ptr(o_ind_ptr), .o_data(i_ind_data));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task run_op(input cmac_op_type op, output logic [7:0] c);
    i_issue = '{1'b1, op};
    @(negedge i_clk_sys);
    i_issue.valid = 1'b0;
    c = 8'h01;
    while (o_done !== 1'b1 && c < 8'h28) begin
      @(negedge i_clk_sys);
      c = c + 8'h01;
    end
  endtask
  task t_addr;
    i_pc = 24'h123457; i_int_mode0 = 1'b1; i_vec_num = 8'h3f; i_ind_addr = 8'hc4;
    i_ea_req = '{32'h1200ffff, 32'h00000001, 1'b0, 1'b1};
    @(negedge i_clk_sys);
    chk(o_mode_adv, 1'b1);
    chk(o_mode_invalid, 1'b0);
    chk(o_fetch_addr, 24'h123456);
    chk(o_push_ext, 1'b0);
    chk(o_vec_addr, 24'h0000fc);
    chk(o_ind_ptr, 24'h0000c4);
    chk(o_ea_rsp.addr, 24'h00ffff);
    chk(o_ea_rsp.reg_upd, 32'h12010000);
    i_int_mode0 = 1'b0;
    i_ea_req = '{32'hab000000, 32'h00000002, 1'b1, 1'b0};
    @(negedge i_clk_sys);
    chk(o_push_ext, 1'b1);
    chk(o_ind_target, 24'h3b3cc4);
    chk(o_ea_rsp.addr, 24'hfffffe);
    chk(o_ea_rsp.reg_upd, 32'haafffffe);
    $display("address test done");
  endtask
  task t_ops;
    cmac_op_type ops [20];
    logic [7:0] n [20];
    logic [7:0] c;
    ops = '{OP_ADD, OP_MUL8, OP_MUL16, OP_DIV16, OP_DIV32, OP_UNSIGNED_EXTEND_MULTIPLY, OP_SIGNED_EXTEND_MULTIPLY, OP_ACLR,
      OP_ALD, OP_AST, OP_MAC, OP_UNSIGNED_EXTEND_MULTIPLY, OP_MAC, OP_SIGNED_EXTEND_MULTIPLY, OP_MAC, OP_ACLR, OP_MAC, OP_ALD,
      OP_MAC, OP_AST};
    n = '{1, 2, 3, 12, 20, 2, 3, 1, 1, 1, 1, 3, 1, 4, 1, 2, 1, 2, 1, 2};
    for (int i = 0; i < 20; i++) begin
      run_op(ops[i], c);
      chk(c, n[i]);
    end
    $display("timing test done");
  endtask
  task t_sleep;
    logic [7:0] c;
    run_op(OP_SLEEP, c);
    chk(c, 8'h01);
    repeat (5) @(negedge i_clk_sys);
    chk(o_sleep, 1'b1);
    i_wake = 1'b1;
    @(negedge i_clk_sys);
    i_wake = 1'b0;
    chk(o_sleep, 1'b0);
    $display("sleep test done");
  endtask
  task t_norm;
    i_mode_pin = 2'h0; i_rst = 1'b1;
    i_pc = 24'h123457; i_vec_num = 8'h3f; i_ind_addr = 8'hc4;
    i_ea_req = '{32'h1200ffff, 32'h00000001, 1'b0, 1'b1};
    repeat (4) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    chk(o_mode_invalid, 1'b1);
    chk(o_mode_adv, 1'b0);
    chk(o_fetch_addr, 24'h003456);
    chk(o_vec_addr, 24'h00007e);
    chk(o_ind_ptr, 24'h0000c4);
    chk(o_ind_target, 24'h003cc4);
    chk(o_ea_rsp.addr, 24'h00ffff);
    chk(o_ea_rsp.reg_upd, 32'h12010000);
    i_mode_pin = 2'h1;
    repeat (4) @(negedge i_clk_sys);
    chk(o_mode_invalid, 1'b1);
    $display("normal mode test done");
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    i_rst = 1'b1; i_mode_pin = 2'h1; i_wake = 1'b0; i_issue = '0; i_ea_req = '0;
    i_vec_num = 8'h00; i_ind_addr = 8'h00; i_pc = 24'h000000; i_int_mode0 = 1'b0;
    repeat (12) @(negedge i_clk_sys);
    i_rst = 1'b0;
    @(negedge i_clk_sys);
    t_addr;
    t_ops;
    t_sleep;
    t_norm;
    end_sim;
  end
endmodule
bind cmac_core cmac_core_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wake(i_wake),
  .i_issue(i_issue), .i_pc(i_pc), .i_int_mode0(i_int_mode0), .o_mode_adv(o_mode_adv),
  .o_fetch_addr(o_fetch_addr), .o_push_ext(o_push_ext), .o_ready(o_ready),
  .o_done(o_done), .o_sleep(o_sleep));
